// ---- rtl/dnsb_regs.svh ----
`ifndef DNSB_REGS_SVH
`define DNSB_REGS_SVH
`define DNSB_SRC_SW 2'h0
`define DNSB_SRC_SYSREF 2'h1
`define DNSB_SRC_FAST 2'h2
`define DNSB_SRC_LSB 2'h3
`define DNSB_RUN_LAST 3'h3
`define DNSB_OM_BYPASS 2'h0
`define DNSB_OM_LOW 2'h1
`define DNSB_OM_HIGH 2'h2
`define DNSB_FIFO_DEPTH 16
`define DNSB_GAIN_FRAC 2
`define DNSB_HB_CTR 32'sh0000_0800
`define DNSB_HB_SHIFT 11
`define DNSB_HB_HALF 32'sh0000_0400
`define DNSB_HB_COEFS {-13'sh009, 13'sh013, -13'sh027, 13'sh046, -13'sh07A, 13'sh0D3, -13'sh193, 13'sh50D}
`endif

// ---- rtl/dnsb_pkg.sv ----
package dnsb_pkg;
    // one complex sample, I then Q
    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } dnsb_iq_t;
    // nco update mode after decode
    typedef enum logic [2:0] {
        DNSB_COHERENT = 3'b001,
        DNSB_CONTINUOUS = 3'b010,
        DNSB_PHRESET = 3'b100
    } dnsb_mode_t;
    // in-band sync pattern detector
    typedef enum logic [2:0] {
        DNSB_SEEK = 3'b001,
        DNSB_ARMED = 3'b010,
        DNSB_RISE = 3'b100
    } dnsb_det_t;
endpackage : dnsb_pkg

// ---- rtl/dnsb_top.sv ----
`timescale 1ns/10ps
`include "dnsb_regs.svh"

module dnsb_fifo #(
    parameter int W = 32,
    parameter int D = `DNSB_FIFO_DEPTH
) (
    input wire logic clk, // core clock
    input wire logic reset, // async, high
    input wire logic wr_valid, // source offers a word
    input wire logic [W-1:0] wr_data, // word in
    output logic wr_ready, // room left
    output logic rd_valid, // word at head
    output logic [W-1:0] rd_data, // head word
    input wire logic rd_ready // drain takes head
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff, rp_ff;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop, rdy_ff;

    assign push = wr_valid && rdy_ff;
    assign pop = rd_valid && rd_ready;
    assign rd_valid = (cnt_ff != '0);
    assign rd_data = mem[rp_ff];
    assign wr_ready = rdy_ff;
    assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

    // storage has no reset, only pointers, count and ready flag do
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= wr_data;
        end
    end

    // pointers wrap explicitly so depth need not be a power of two
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            if (push) begin
                wp_ff <= (wp_ff == AW'(D-1)) ? '0 : wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= (rp_ff == AW'(D-1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            rdy_ff <= (nxt_cnt != (AW+1)'(D));
        end
    end

    full_ready_a: assert property (@(posedge clk) disable iff (reset)
        cnt_ff == (AW+1)'(D) |-> !wr_ready)
        else $error("fifo full yet ready");
endmodule : dnsb_fifo

module dnsb_top
    import dnsb_pkg::*;
#(
    parameter int NDUC = 4,
    parameter int PHW = 32
) (
    input wire logic clk, // core clock
    input wire logic reset, // async, high
    input wire logic in_valid, // transport offers a sample set
    input wire dnsb_iq_t [NDUC-1:0] in_data, // one sample per DUC
    output logic in_ready, // fifo has room
    input wire logic link_complex, // link mode carries complex data
    input wire logic [NDUC-1:0][PHW-1:0] freq_word, // frequency words
    input wire logic [NDUC-1:0] accumulator_reset_sel, // port-path reset mode
    input wire logic [NDUC-1:0] continuous_sel, // continuous mode
    input wire logic [NDUC-1:0] fast_path_accum_reset_sel, // fast-path reset mode
    input wire logic fast_port_enable, // fast port owns updates
    input wire logic [1:0] sync_source_sel, // trigger source
    input wire logic software_sync_bit, // software sync level
    input wire logic sysref, // sysref pin
    input wire logic fast_port_select, // fast port select pin
    input wire logic fast_path_sync_arm, // arm select-edge update
    input wire logic [NDUC-1:0][1:0] upconverter_gain_sel, // per-Upconverter_gain_sel
    input wire logic [NDUC-1:0] converter_source_sel, // DUC joins sum
    input wire logic [1:0] complex_out_sel, // DUC0/1 complex output
    input wire logic [1:0] des_mode_sel, // bypass, low or high
    input wire logic des_src_raw, // interpolate raw input
    input wire logic out_ready, // downstream accepts
    output dnsb_iq_t out_rise, // sample for rising edge
    output dnsb_iq_t out_fall, // sample for falling edge
    output logic out_valid, // new pair this cycle
    output logic lsb_mode, // LSB carries sync
    output logic sync_fired // nco update pulse
);
    localparam logic [103:0] HBP = `DNSB_HB_COEFS;

    logic f_valid, adv, lsb_on, lsb_evt, trig, evt, din_lsb;
    dnsb_iq_t [NDUC-1:0] f_data, din;
    logic sw_prev_ff, sr_m_ff, sr_s_ff, sr_prev_ff;
    logic fp_m_ff, fp_s_ff, fp_prev_ff, pend_ff, rel_ff;
    logic [PHW-1:0] tick_ff;
    dnsb_det_t det_ff;
    logic [2:0] run_ff;
    dnsb_iq_t [NDUC-1:0] mix_ff;
    dnsb_iq_t raw1_ff, raw2_ff, bond_ff;
    logic alt_ff, outv_ff, sync_ff;
    dnsb_iq_t rise_ff, fall_ff;
    logic signed [19:0] sum_i, sum_q;

    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > 32'sh0000_7FFF) begin
            return 16'h7FFF;
        end
        if (v < -32'sh0000_8000) begin
            return 16'h8000;
        end
        return v[15:0];
    endfunction : sat16

    function automatic logic signed [19:0] scl(input logic signed [15:0] x,
                                                input logic [1:0] g);
        logic signed [19:0] w;
        w = 20'(x) <<< `DNSB_GAIN_FRAC;
        return (g == 2'h0) ? w : (g == 2'h1) ? (w >>> 1) : (w >>> 2);
    endfunction : scl

    dnsb_fifo #(.W($bits(dnsb_iq_t)*NDUC), .D(`DNSB_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .reset(reset),
        .wr_valid(in_valid),
        .wr_data(in_data),
        .wr_ready(in_ready),
        .rd_valid(f_valid),
        .rd_data(f_data),
        .rd_ready(out_ready)
    );

    // the whole datapath steps once per popped sample set
    assign adv = f_valid && out_ready;
    assign lsb_on = software_sync_bit && (sync_source_sel == `DNSB_SRC_LSB)
                    && link_complex && !rel_ff;

    // DUC0 I bit 0 becomes a flag, its upper bits, its Q and the other DUCs stay data
    always_comb begin
        din = f_data;
        if (lsb_on) begin
            din[0].i[0] = 1'b0;
        end
    end

    // two-stage synchronisers for the pins, edge detect on the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sr_m_ff <= 1'b0;
            sr_s_ff <= 1'b0;
            sr_prev_ff <= 1'b0;
            fp_m_ff <= 1'b0;
            fp_s_ff <= 1'b0;
            fp_prev_ff <= 1'b0;
            sw_prev_ff <= 1'b0;
        end else begin
            sr_m_ff <= sysref;
            sr_s_ff <= sr_m_ff;
            sr_prev_ff <= sr_s_ff;
            fp_m_ff <= fast_port_select;
            fp_s_ff <= fp_m_ff;
            fp_prev_ff <= fp_s_ff;
            sw_prev_ff <= software_sync_bit;
        end
    end

    // one shared trigger reaches every nco in the same cycle
    always_comb begin
        trig = fast_path_sync_arm && fp_s_ff && !fp_prev_ff;
        case (sync_source_sel)
            `DNSB_SRC_SW: trig = trig || (software_sync_bit && !sw_prev_ff);
            `DNSB_SRC_SYSREF: trig = trig || (sr_s_ff && !sr_prev_ff);
            default: trig = trig;
        endcase
    end
    assign evt = adv && (pend_ff || trig || lsb_evt);

    // a trigger between samples waits for the next one; a trigger that
    // meets a step is applied at once, so holding it too would fire twice
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_ff <= 1'b0;
        end else begin
            pend_ff <= (trig || pend_ff) && !adv;
        end
    end

    // fast-port update hands the LSB back to data once it fires
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rel_ff <= 1'b0;
        end else if (evt && fast_port_enable && lsb_on) begin
            rel_ff <= 1'b1;
        end else if (!software_sync_bit) begin
            rel_ff <= 1'b0;
        end
    end

    // four lows arm, the fourth high in a row fires
    assign din_lsb = f_data[0].i[0];
    assign lsb_evt = lsb_on && (det_ff == DNSB_RISE) && din_lsb
                     && (run_ff == `DNSB_RUN_LAST);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            det_ff <= DNSB_SEEK;
            run_ff <= 3'h0;
        end else if (!lsb_on) begin
            det_ff <= DNSB_SEEK;
            run_ff <= 3'h0;
        end else if (adv) begin
            case (det_ff)
                DNSB_SEEK: begin
                    run_ff <= din_lsb ? 3'h0 : run_ff + 3'h1;
                    if (!din_lsb && run_ff == `DNSB_RUN_LAST) begin
                        det_ff <= DNSB_ARMED;
                        run_ff <= 3'h0;
                    end
                end
                DNSB_ARMED: begin
                    if (din_lsb) begin
                        det_ff <= DNSB_RISE;
                        run_ff <= 3'h1;
                    end
                end
                DNSB_RISE: begin
                    if (!din_lsb) begin
                        det_ff <= DNSB_SEEK;
                        run_ff <= 3'h1;
                    end else if (run_ff == `DNSB_RUN_LAST) begin
                        det_ff <= DNSB_SEEK;
                        run_ff <= 3'h0;
                    end else begin
                        run_ff <= run_ff + 3'h1;
                    end
                end
                default: begin
                    det_ff <= DNSB_SEEK;
                    run_ff <= 3'h0;
                end
            endcase
        end
    end

    // free-running sample counter for coherent phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_ff <= '0;
        end else if (adv) begin
            tick_ff <= tick_ff + 1'b1;
        end
    end

    // one nco and quadrant mixer per DUC, each with its own mode bits
    for (genvar n = 0; n < NDUC; n++) begin : nco
        logic [PHW-1:0] acc_ff, freq_ff, ph;
        logic ar;
        dnsb_mode_t mode;
        logic signed [15:0] xi, xq;

        assign ar = fast_port_enable ? fast_path_accum_reset_sel[n]
                                     : accumulator_reset_sel[n];
        assign mode = ar ? DNSB_PHRESET :
                      continuous_sel[n] ? DNSB_CONTINUOUS : DNSB_COHERENT;
        assign ph = (mode == DNSB_COHERENT) ? PHW'(freq_ff * tick_ff) : acc_ff;

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                acc_ff <= '0;
                freq_ff <= '0;
            end else if (adv) begin
                acc_ff <= acc_ff + freq_ff;
                if (evt) begin
                    freq_ff <= freq_word[n];
                    if (mode == DNSB_PHRESET) begin
                        acc_ff <= '0;
                    end
                end
            end
        end

        // rotation by quarter turns keeps unity gain; negation saturates
        always_comb begin
            case (ph[PHW-1 -: 2])
                2'h0: begin
                    xi = din[n].i;
                    xq = din[n].q;
                end
                2'h1: begin
                    xi = sat16(-32'(din[n].q));
                    xq = din[n].i;
                end
                2'h2: begin
                    xi = sat16(-32'(din[n].i));
                    xq = sat16(-32'(din[n].q));
                end
                default: begin
                    xi = din[n].q;
                    xq = sat16(-32'(din[n].i));
                end
            endcase
        end

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                mix_ff[n] <= '0;
            end else if (adv) begin
                mix_ff[n] <= '{i: xi, q: xq};
            end
        end
    end

    // bonder: scaled full-precision sum; only DUC0/1 may be complex
    always_comb begin
        sum_i = '0;
        sum_q = '0;
        for (int k = 0; k < NDUC; k++) begin
            if (converter_source_sel[k]) begin
                sum_i = sum_i + scl(mix_ff[k].i, upconverter_gain_sel[k]);
                if (k < 2 && complex_out_sel[k % 2]) begin
                    sum_q = sum_q + scl(mix_ff[k].q, upconverter_gain_sel[k]);
                end
            end
        end
    end

    // round half up and saturate the combined value only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bond_ff <= '0;
            raw1_ff <= '0;
            raw2_ff <= '0;
        end else if (adv) begin
            bond_ff.i <= sat16(32'((sum_i + 20'sh00002) >>> `DNSB_GAIN_FRAC));
            bond_ff.q <= sat16(32'((sum_q + 20'sh00002) >>> `DNSB_GAIN_FRAC));
            raw1_ff <= din[0];
            raw2_ff <= raw1_ff;
        end
    end

    // spectrum inversion flips sign every input sample
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alt_ff <= 1'b0;
        end else if (adv) begin
            alt_ff <= !alt_ff;
        end
    end

    // half-band interpolator per lane: even tap is the center,
    // odd phase is the symmetric sum; two words leave each clock
    for (genvar l = 0; l < 2; l++) begin : des
        logic signed [15:0] d_ff [16];
        logic signed [15:0] src, ev, od, r_n, f_n;
        logic signed [31:0] acc;

        assign src = des_src_raw ? ((l == 0) ? raw2_ff.i : raw2_ff.q)
                                 : ((l == 0) ? bond_ff.i : bond_ff.q);

        always_comb begin
            acc = '0;
            for (int k = 0; k < 8; k++) begin
                acc = acc + 32'($signed(HBP[k*13 +: 13]))
                      * (32'(d_ff[7-k]) + 32'(d_ff[8+k]));
            end
            ev = sat16((32'(d_ff[8]) * `DNSB_HB_CTR + `DNSB_HB_HALF) >>> `DNSB_HB_SHIFT);
            od = sat16((acc + `DNSB_HB_HALF) >>> `DNSB_HB_SHIFT);
            case (des_mode_sel)
                `DNSB_OM_HIGH: begin
                    r_n = ev;
                    f_n = sat16(-32'(od));
                end
                `DNSB_OM_LOW: begin
                    r_n = alt_ff ? sat16(-32'(ev)) : ev;
                    f_n = alt_ff ? sat16(-32'(od)) : od;
                end
                default: begin
                    r_n = src;
                    f_n = src;
                end
            endcase
        end

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                for (int k = 0; k < 16; k++) begin
                    d_ff[k] <= '0;
                end
            end else if (adv) begin
                d_ff[0] <= src;
                for (int k = 1; k < 16; k++) begin
                    d_ff[k] <= d_ff[k-1];
                end
            end
        end
    end

    // output pair: the pad mux shows fall on the falling edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rise_ff <= '0;
            fall_ff <= '0;
            outv_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            outv_ff <= adv;
            sync_ff <= evt;
            if (adv) begin
                rise_ff <= '{i: des[0].r_n, q: des[1].r_n};
                fall_ff <= '{i: des[0].f_n, q: des[1].f_n};
            end
        end
    end

    // status level mirrors the LSB usage one cycle late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lsb_mode <= 1'b0;
        end else begin
            lsb_mode <= lsb_on;
        end
    end

    assign out_rise = rise_ff;
    assign out_fall = fall_ff;
    assign out_valid = outv_ff;
    assign sync_fired = sync_ff;

    reset_mode_a: assert property (@(posedge clk) disable iff (reset)
        evt && nco[0].mode == DNSB_PHRESET |=> nco[0].acc_ff == '0)
        else $error("reset mode left accumulator");
    freq_load_a: assert property (@(posedge clk) disable iff (reset)
        evt |=> nco[0].freq_ff == $past(freq_word[0])
                && nco[NDUC-1].freq_ff == $past(freq_word[NDUC-1]))
        else $error("frequency not loaded together");
    cont_keep_a: assert property (@(posedge clk) disable iff (reset)
        evt && nco[0].mode == DNSB_CONTINUOUS |=>
        nco[0].acc_ff == $past(nco[0].acc_ff) + $past(nco[0].freq_ff))
        else $error("continuous mode lost phase");
    det_clear_a: assert property (@(posedge clk) disable iff (reset)
        !lsb_on |=> det_ff == DNSB_SEEK && run_ff == 3'h0)
        else $error("detector kept history");
    lsb_fire_a: assert property (@(posedge clk) disable iff (reset)
        lsb_evt |-> $past(det_ff != DNSB_SEEK, 3) && din_lsb && lsb_on)
        else $error("sync fired without pattern");
    lsb_strip_a: assert property (@(posedge clk) disable iff (reset)
        adv && lsb_on |=> raw1_ff.i[0] == 1'b0 && raw1_ff.q == $past(f_data[0].q))
        else $error("sync bit leaked into data");
    lsb_release_a: assert property (@(posedge clk) disable iff (reset)
        evt && fast_port_enable && lsb_on |=> !lsb_on)
        else $error("LSB not released");
    des_high_a: assert property (@(posedge clk) disable iff (reset)
        adv && des_mode_sel == `DNSB_OM_HIGH |=> out_rise.i == $past(des[0].d_ff[8]))
        else $error("high mode center wrong");
endmodule : dnsb_top

// ---- bench/dnsb_src_model.sv ----
`timescale 1ns/10ps

module dnsb_src_model
    import dnsb_pkg::*;
#(
    parameter int NDUC = 4
) (
    input wire logic clk, // core clock
    input wire logic reset, // async, high
    input wire logic run, // keep offering samples
    input wire logic go, // start one sync pattern
    input wire logic [15:0] i_val, // even I value
    input wire logic [3:0] n_high, // high samples in pattern
    input wire logic in_ready, // device has room
    output logic in_valid, // sample set offered
    output dnsb_iq_t [NDUC-1:0] in_data // one sample per DUC
);
    logic [4:0] pat_ff; // taken samples since go, 31 is idle
    logic [15:0] i_ff; // payload held until taken
    logic idle_ff; // flips each cycle so released data never looks stable
    logic sync_b;

    // six lows first, then the requested run of highs
    assign sync_b = (pat_ff >= 5'h06) && (pat_ff < 5'h06 + n_high);

    // pattern position restarts on go, otherwise moves only on a taken sample
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pat_ff <= 5'h1F;
        end else if (go) begin
            pat_ff <= 5'h00;
        end else if (in_valid && in_ready && pat_ff != 5'h1F) begin
            pat_ff <= pat_ff + 5'h01;
        end
    end

    // offer stays unchanged until the device takes it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            in_valid <= 1'b0;
            i_ff <= 16'h0000;
            idle_ff <= 1'b0;
        end else begin
            idle_ff <= ~idle_ff;
            if (!in_valid || in_ready) begin
                in_valid <= run;
                i_ff <= i_val;
            end
        end
    end

    // sync flag rides only in DUC0 I bit 0, Q keeps full width
    always_comb begin
        for (int n = 0; n < NDUC; n++) begin
            in_data[n].i = in_valid ? i_ff : ~i_ff ^ {16{idle_ff}};
            in_data[n].q = in_valid ? ~i_ff : i_ff ^ {16{idle_ff}};
        end
        if (in_valid) begin
            in_data[0].i[0] = sync_b;
        end
    end
endmodule : dnsb_src_model

// ---- bench/duc_nco_sync_bonder_tb.sv ----
`timescale 1ns/10ps

module duc_nco_sync_bonder_tb;
    import dnsb_pkg::*;
    logic clk, reset, run, go, in_valid, in_ready, link_complex, fast_port_enable;
    logic software_sync_bit, sysref, fast_port_select, fast_path_sync_arm;
    logic des_src_raw, out_ready, out_valid, lsb_mode, sync_fired;
    logic [15:0] i_val, s;
    logic [3:0] n_high, accumulator_reset_sel, continuous_sel, fast_path_accum_reset_sel;
    logic [3:0] converter_source_sel;
    logic [1:0] sync_source_sel, complex_out_sel, des_mode_sel;
    logic [3:0][1:0] upconverter_gain_sel;
    logic [3:0][31:0] freq_word;
    dnsb_iq_t [3:0] in_data;
    dnsb_iq_t out_rise, out_fall;
    int miscompares = 0, n_compared = 0, n_sync = 0, n_acc = 0, b, hits;
    // bonder cases: sources, gain, input, expected sum
    logic [3:0] t_src [6] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h3, 4'hF};
    logic [1:0] t_gain [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2};
    logic [15:0] t_in [6] = '{16'h03E8, 16'h03E8, 16'h03E8, 16'h03E8, 16'h4E20, 16'h4E20};
    logic [15:0] t_exp [6] = '{16'h03E8, 16'h01F4, 16'h00FA, 16'h00FA, 16'h7FFF, 16'h4E20};

    dnsb_top u_dnsb_top (.clk, .reset, .in_valid, .in_data, .in_ready, .link_complex,
        .freq_word, .accumulator_reset_sel, .continuous_sel, .fast_path_accum_reset_sel,
        .fast_port_enable, .sync_source_sel, .software_sync_bit, .sysref, .fast_port_select,
        .fast_path_sync_arm, .upconverter_gain_sel, .converter_source_sel, .complex_out_sel,
        .des_mode_sel, .des_src_raw, .out_ready, .out_rise, .out_fall, .out_valid, .lsb_mode,
        .sync_fired);
    dnsb_src_model u_dnsb_src_model (.clk, .reset, .run, .go, .i_val, .n_high, .in_ready,
        .in_valid, .in_data);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // count update pulses and taken samples
    always @(posedge clk) begin
        if (sync_fired === 1'b1) n_sync++;
        if (in_valid === 1'b1 && in_ready === 1'b1) n_acc++;
    end

    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task chk16(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk16
    task chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask : chk_bit
    task pulse_go;
        go = 1'b1;
        tick(1);
        go = 1'b0;
    endtask : pulse_go
    // long enough for a whole pattern plus pipeline and pin synchronisers
    task wait_sync(input int base, input logic [15:0] want);
        tick(60);
        chk16(16'(n_sync - base), want);
    endtask : wait_sync
    task end_of_test;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        miscompares++;
        end_of_test;
    end

    initial begin
        {reset, run, go, i_val, n_high, link_complex, freq_word} = {3'b100, 16'h03E8, 4'h4, 1'b1, 128'h0};
        {accumulator_reset_sel, continuous_sel, fast_path_accum_reset_sel} = 12'h000;
        {fast_port_enable, software_sync_bit, sysref, fast_port_select} = 4'h0;
        {fast_path_sync_arm, des_src_raw, out_ready, sync_source_sel} = 5'b00100;
        {upconverter_gain_sel, converter_source_sel} = 12'h001;
        {complex_out_sel, des_mode_sel} = 4'h0;
        tick(12);
        chk_bit(in_ready, 1'b0);
        chk_bit(out_valid, 1'b0);
        reset = 1'b0;
        tick(2);
        chk_bit(in_ready, 1'b1);
        run = 1'b1;
        // constant stream, so each settled output is the bonded sum
        for (int k = 0; k < 6; k++) begin
            converter_source_sel = t_src[k];
            upconverter_gain_sel = {4{t_gain[k]}};
            i_val = t_in[k];
            tick(40);
            chk16(out_rise.i, t_exp[k]);
            chk16(out_fall.i, t_exp[k]);
        end
        // DUC0 also feeds the Q lane: -20001 times 0.25, rounded half up
        complex_out_sel = 2'h1;
        tick(40);
        chk16(out_rise.q, 16'hEC78);
        complex_out_sel = 2'h0;
        // dc into the half-band: high mode gives 2048 and -2040
        converter_source_sel = 4'h1;
        upconverter_gain_sel = '0;
        i_val = 16'h0800;
        des_mode_sel = 2'h2;
        tick(40);
        chk16(out_rise.i + out_fall.i, 16'h0008);
        des_mode_sel = 2'h1;
        tick(40);
        hits = 0;
        repeat (4) begin
            tick(1);
            s = out_rise.i + out_fall.i;
            if (s === 16'hF008) hits++;
        end
        chk_bit(hits > 0, 1'b1);
        des_mode_sel = 2'h0;
        // half-turn word: sign flips each sample, -32768 must clip
        i_val = 16'h8000;
        freq_word = {4{32'h8000_0000}};
        continuous_sel = 4'hF;
        b = n_sync;
        software_sync_bit = 1'b1;
        wait_sync(b, 16'h0001);
        hits = 0;
        repeat (8) begin
            tick(1);
            if (out_rise.i === 16'h7FFF) hits++;
        end
        chk_bit(hits > 0, 1'b1);
        software_sync_bit = 1'b0;
        sync_source_sel = 2'h1;
        accumulator_reset_sel = 4'hF;
        b = n_sync;
        sysref = 1'b1;
        wait_sync(b, 16'h0001);
        sysref = 1'b0;
        accumulator_reset_sel = 4'h0;
        sync_source_sel = 2'h2;
        b = n_sync;
        fast_port_select = 1'b1;
        wait_sync(b, 16'h0000);
        fast_port_select = 1'b0;
        fast_path_sync_arm = 1'b1;
        tick(5);
        b = n_sync;
        fast_port_select = 1'b1;
        wait_sync(b, 16'h0001);
        {fast_port_select, fast_path_sync_arm} = 2'b00;
        // in-band sync: refused on a real link, then short and full patterns
        sync_source_sel = 2'h3;
        software_sync_bit = 1'b1;
        link_complex = 1'b0;
        tick(3);
        chk_bit(lsb_mode, 1'b0);
        b = n_sync;
        pulse_go;
        wait_sync(b, 16'h0000);
        link_complex = 1'b1;
        tick(3);
        chk_bit(lsb_mode, 1'b1);
        n_high = 4'h3;
        b = n_sync;
        pulse_go;
        wait_sync(b, 16'h0000);
        n_high = 4'h4;
        b = n_sync;
        pulse_go;
        wait_sync(b, 16'h0001);
        chk_bit(lsb_mode, 1'b1);
        software_sync_bit = 1'b0;
        tick(3);
        chk_bit(lsb_mode, 1'b0);
        fast_port_enable = 1'b1;
        software_sync_bit = 1'b1;
        tick(3);
        b = n_sync;
        pulse_go;
        wait_sync(b, 16'h0001);
        chk_bit(lsb_mode, 1'b0);
        {fast_port_enable, software_sync_bit} = 2'b00;
        // stall the drain: exactly sixteen samples get in, then drain empty
        run = 1'b0;
        tick(30);
        out_ready = 1'b0;
        b = n_acc;
        run = 1'b1;
        tick(40);
        chk16(16'(n_acc - b), 16'h0010);
        chk_bit(in_ready, 1'b0);
        out_ready = 1'b1;
        run = 1'b0;
        tick(40);
        chk_bit(in_ready, 1'b1);
        chk_bit(out_valid, 1'b0);
        end_of_test;
    end
endmodule : duc_nco_sync_bonder_tb
